// ==== hdl/dcmrb_register_bank.sv ====
// Register bank of a dual-slot card multiplexer reached by the serial control port.
//
// Behaviour
// - Status bit 0 shows synchronised shutdown pin.
// - Status read clears both interrupt flags.
// - Status bit 3 holds battery removal flag.
// - Status bit 2 shows battery removed.
// - Slot status fields use four-state encoding.
// - Slot status derives from state and enable.
// - Hardware revision is read-only identification byte.
// - Manufacturer nibble fixed, identifies maker.
// - Driver revision read-only, initial 00h.
// - Enable zero forces slot status 00.
// - Slot state fields at 3:2, 7:6.
`timescale 1ns/1ps
`default_nettype none
`include "dcmrb_params.svh"

module dcmrb_register_bank #(
  parameter logic [3:0] MFR_CODE  = 4'h5,  // Arbitrary manufacturer nibble.
  parameter logic [3:0] DEV_CODE  = 4'h3,  // Arbitrary device nibble.
  parameter int         TEST_REGS = 5      // Factory test registers from 10h.
) (
  input  wire logic       i_clock,             // 100 MHz system clock.
  input  wire logic       i_srst,              // Synchronous reset, active high.
  input  wire logic       i_wr_en,             // Register write strobe.
  input  wire logic       i_rd_en,             // Register read strobe.
  input  wire logic [7:0] i_addr,              // Register offset.
  input  wire logic [7:0] i_wdata,             // Write data.
  input  wire logic       i_slot_two_shutdown_input, // Raw shutdown pin.
  input  wire logic       i_shutdown_detected, // Debounced shutdown level.
  input  wire logic       i_battery_removed,   // Battery debounce expired level.
  output logic      [7:0] o_rdata,             // Read data.
  output logic            o_rd_valid,          // Read answer pulse.
  output logic      [7:0] o_slot_control,      // Slot interface control.
  output logic      [7:0] o_battery_debounce,  // Battery debounce count.
  output logic      [7:0] o_shutdown_debounce, // Shutdown debounce count.
  output logic      [7:0] o_clock_control,     // Clock source control.
  output logic      [7:0] o_device_control,    // Detection and direction control.
  output logic      [7:0] o_gp_pullup,         // General purpose pull-up control.
  output logic      [7:0] o_status             // Live status byte.
);

  // ========================================================================
  // Elaboration checks
  // ========================================================================
  // Only five addresses sit between the test base and the pull-up register.
  if (TEST_REGS < 1 || TEST_REGS > 5) begin : g_bad_test_regs
    $error("TEST_REGS must lie between 1 and 5");
  end

  // ========================================================================
  // Constants and state
  // ========================================================================
  // fixed maker nibble
  localparam logic [7:0] HW_ID = {MFR_CODE, DEV_CODE}; // Identification byte.

  dcmrb_pkg::dcmrb_state_t r;       // Registered state.
  dcmrb_pkg::dcmrb_state_t next_r;  // Next state.
  dcmrb_pkg::dcmrb_slot_t  slot1_enc; // Encoder output for slot one.
  dcmrb_pkg::dcmrb_slot_t  slot2_enc; // Encoder output for slot two.
  logic [7:0]              status_byte; // Status as the host sees it.
  logic                    status_read; // Read of the status register.
  logic                    shd_rise;    // Shutdown detection became active.
  logic                    bat_rise;    // Battery removal became active.

  // ========================================================================
  // Slot status encoders
  // ========================================================================
  // status from state and enable
  dcmrb_slot_status u_slot_one (
    .i_state  (r.slot_ctrl[`DCMRB_SC_SLOT1_STATE +: 2]),
    .i_enable (r.slot_ctrl[`DCMRB_SC_SLOT1_EN]),
    .o_status (slot1_enc)
  );

  dcmrb_slot_status u_slot_two (
    .i_state  (r.slot_ctrl[`DCMRB_SC_SLOT2_STATE +: 2]),
    .i_enable (r.slot_ctrl[`DCMRB_SC_SLOT2_EN]),
    .o_status (slot2_enc)
  );

  // ========================================================================
  // Status byte
  // ========================================================================
  // Assembled from registered fields only, so a read returns a coherent byte.
  always_comb begin
    status_byte = {r.slot2_st, r.slot1_st, r.bat_int, r.bat_gone, r.shd_int, r.shd_level};
  end

  // ========================================================================
  // Next state
  // ========================================================================
  // One process computes every register; the flop below only stores it.
  always_comb begin
    next_r      = r;
    status_read = i_rd_en && (i_addr == `DCMRB_OFF_STATUS);
    shd_rise    = i_shutdown_detected && !r.shd_prev;
    bat_rise    = i_battery_removed && !r.bat_gone;

    next_r.shd_meta  = i_slot_two_shutdown_input;
    next_r.shd_level = r.shd_meta;
    next_r.shd_prev  = i_shutdown_detected;
    next_r.bat_gone  = i_battery_removed;

    if (status_read) begin
      next_r.shd_int = 1'b0;
      next_r.bat_int = 1'b0;
    end
    if (shd_rise && r.dev_ctrl[`DCMRB_DC_SHD_INT_EN]) begin
      next_r.shd_int = 1'b1;
    end
    if (bat_rise && r.dev_ctrl[`DCMRB_DC_BAT_INT_EN]) begin
      next_r.bat_int = 1'b1;
    end

    next_r.slot1_st = slot1_enc;
    next_r.slot2_st = slot2_enc;

    // Writes. read-only offsets fall through untouched.
    if (i_wr_en) begin
      unique case (i_addr)
        `DCMRB_OFF_SLOT_CTRL: next_r.slot_ctrl = i_wdata;
        `DCMRB_OFF_BAT_DEB:   next_r.bat_deb   = i_wdata;
        `DCMRB_OFF_SHD_DEB:   next_r.shd_deb   = i_wdata;
        `DCMRB_OFF_CLK_CTRL:  next_r.clk_ctrl  = i_wdata;
        `DCMRB_OFF_DEV_CTRL:  next_r.dev_ctrl  = i_wdata;
        `DCMRB_OFF_GP_PULLUP: next_r.gp_pullup = i_wdata;
        default: begin
          // Test registers occupy a contiguous window above the base.
          for (int k = 0; k < TEST_REGS; k++) begin
            if (i_addr == `DCMRB_OFF_TEST_FIRST + 8'(k)) begin
              next_r.test[k] = i_wdata;
            end
          end
        end
      endcase
    end

    // Reads. Unmapped and reserved offsets answer zero.
    next_r.rvalid = i_rd_en;
    if (i_rd_en) begin
      unique case (i_addr)
        `DCMRB_OFF_HW_REV:    next_r.rdata = HW_ID;
        `DCMRB_OFF_DRV_REV:   next_r.rdata = `DCMRB_RST_DRV_REV;
        `DCMRB_OFF_STATUS:    next_r.rdata = status_byte;
        `DCMRB_OFF_SLOT_CTRL: next_r.rdata = r.slot_ctrl;
        `DCMRB_OFF_BAT_DEB:   next_r.rdata = r.bat_deb;
        `DCMRB_OFF_SHD_DEB:   next_r.rdata = r.shd_deb;
        `DCMRB_OFF_CLK_CTRL:  next_r.rdata = r.clk_ctrl;
        `DCMRB_OFF_DEV_CTRL:  next_r.rdata = r.dev_ctrl;
        `DCMRB_OFF_GP_PULLUP: next_r.rdata = r.gp_pullup;
        default: begin
          next_r.rdata = `DCMRB_RST_ZERO;
          for (int k = 0; k < TEST_REGS; k++) begin
            if (i_addr == `DCMRB_OFF_TEST_FIRST + 8'(k)) begin
              next_r.rdata = r.test[k];
            end
          end
        end
      endcase
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  // Synchronous reset puts every control field at its power-up value.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      r.shd_meta  <= 1'b0;
      r.shd_level <= 1'b0;
      r.shd_prev  <= 1'b0;
      r.shd_int   <= 1'b0;
      r.bat_gone  <= 1'b0;
      r.bat_int   <= 1'b0;
      r.slot_ctrl <= `DCMRB_RST_ZERO;
      r.bat_deb   <= `DCMRB_RST_DEBOUNCE;
      r.shd_deb   <= `DCMRB_RST_DEBOUNCE;
      r.clk_ctrl  <= `DCMRB_RST_ZERO;
      r.dev_ctrl  <= `DCMRB_RST_ZERO;
      r.gp_pullup <= `DCMRB_RST_ZERO;
      r.test      <= '0;
      r.slot1_st  <= dcmrb_pkg::DCMRB_SLOT_DOWN;
      r.slot2_st  <= dcmrb_pkg::DCMRB_SLOT_DOWN;
      r.rdata     <= `DCMRB_RST_ZERO;
      r.rvalid    <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // All straight from the state flops.
  assign o_rdata             = r.rdata;
  assign o_rd_valid          = r.rvalid;
  assign o_slot_control      = r.slot_ctrl;
  assign o_battery_debounce  = r.bat_deb;
  assign o_shutdown_debounce = r.shd_deb;
  assign o_clock_control     = r.clk_ctrl;
  assign o_device_control    = r.dev_ctrl;
  assign o_gp_pullup         = r.gp_pullup;
  assign o_status            = status_byte;

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  // The status level bit shows the pin as sampled two edges earlier.
  chk_shd_pin_level: assert property (
    ##2 (o_status[`DCMRB_ST_SHD_LEVEL] == $past(i_slot_two_shutdown_input, 2)))
    else $error("shutdown level bit does not follow the pin");

  // A status read without a new event leaves both flags clear.
  chk_read_clears: assert property (
    (i_rd_en && i_addr == `DCMRB_OFF_STATUS && !shd_rise && !bat_rise)
      |=> (!o_status[`DCMRB_ST_SHD_INT] && !o_status[`DCMRB_ST_BAT_INT]))
    else $error("status read did not clear the interrupt flags");

  // An enabled shutdown edge sets its flag even during a status read.
  chk_shd_flag_set: assert property (
    (shd_rise && o_device_control[`DCMRB_DC_SHD_INT_EN]) |=> o_status[`DCMRB_ST_SHD_INT])
    else $error("shutdown interrupt flag not set");

  // An enabled battery removal edge sets the flag even during a read.
  chk_bat_flag_set: assert property (
    (bat_rise && o_device_control[`DCMRB_DC_BAT_INT_EN]) |=> o_status[`DCMRB_ST_BAT_INT])
    else $error("battery removal flag not set");

  // The flag never rises without an enabled removal edge.
  chk_bat_flag_cause: assert property (
    $rose(o_status[`DCMRB_ST_BAT_INT]) |-> $past(bat_rise && o_device_control[`DCMRB_DC_BAT_INT_EN]))
    else $error("battery removal flag rose without cause");

  // The removed bit tracks the debounce result one edge later.
  chk_bat_level: assert property (
    ##1 (o_status[`DCMRB_ST_BAT_GONE] == $past(i_battery_removed)))
    else $error("battery removed bit wrong");

  // Active state with enable reads back as active two edges after the write.
  chk_slot_active: assert property (
    (i_wr_en && i_addr == `DCMRB_OFF_SLOT_CTRL && i_wdata[`DCMRB_SC_SLOT1_STATE +: 2] == 2'b11
      && i_wdata[`DCMRB_SC_SLOT1_EN]) ##1 (!i_wr_en)
      |=> (o_status[`DCMRB_ST_SLOT1_LO +: 2] == 2'b11))
    else $error("slot one active state not reported");

  // Slot two status equals its control bits when powered and the state field is not 00.
  chk_slot_derive: assert property (
    ($stable(o_slot_control) && o_slot_control[`DCMRB_SC_SLOT2_EN]
      && o_slot_control[`DCMRB_SC_SLOT2_STATE +: 2] != 2'b00)
      |=> (o_status[`DCMRB_ST_SLOT2_LO +: 2] == $past(o_slot_control[`DCMRB_SC_SLOT2_STATE +: 2])))
    else $error("slot two status not derived from control");

  // An unpowered slot one reports down.
  chk_slot_off: assert property (
    (!o_slot_control[`DCMRB_SC_SLOT1_EN] && $stable(o_slot_control))
      |=> (o_status[`DCMRB_ST_SLOT1_LO +: 2] == 2'b00))
    else $error("unpowered slot one not reported down");

  // An unpowered slot two reports down as well.
  chk_slot_two_off: assert property (
    (!o_slot_control[`DCMRB_SC_SLOT2_EN] && $stable(o_slot_control))
      |=> (o_status[`DCMRB_ST_SLOT2_LO +: 2] == 2'b00))
    else $error("unpowered slot two not reported down");

  // The identification byte carries the fixed manufacturer nibble.
  chk_hw_id: assert property (
    (i_rd_en && i_addr == `DCMRB_OFF_HW_REV) |=> (o_rd_valid && o_rdata[7:4] == MFR_CODE))
    else $error("identification byte wrong");

  // The driver revision always reads zero.
  chk_drv_rev: assert property (
    (i_rd_en && i_addr == `DCMRB_OFF_DRV_REV) |=> (o_rdata == 8'h00))
    else $error("driver revision not zero");

  // A write to the status offset changes no flag by itself.
  chk_ro_write: assert property (
    (i_wr_en && i_addr == `DCMRB_OFF_STATUS && !i_rd_en && !shd_rise && !bat_rise)
      |=> ($stable(o_status[`DCMRB_ST_BAT_INT]) && $stable(o_status[`DCMRB_ST_SHD_INT])))
    else $error("write to status disturbed a flag");

  // ========================================================================
  // Cover points
  // ========================================================================
  // Main scenarios that the tests are expected to reach.
  cov_bat_int:   cover property (bat_rise && o_device_control[`DCMRB_DC_BAT_INT_EN] ##1 status_read);
  cov_shd_int:   cover property ($rose(o_status[`DCMRB_ST_SHD_INT]));
  cov_slot_act:  cover property (o_status[`DCMRB_ST_SLOT1_LO +: 2] == 2'b11);
  cov_slot_iso:  cover property (o_status[`DCMRB_ST_SLOT2_LO +: 2] == 2'b01);
  cov_set_clear: cover property (status_read && bat_rise);

endmodule

`default_nettype wire

// ==== hdl/dcmrb_params.svh ====
// Offsets, field positions and reset values of the dual card mux register bank.
`ifndef DCMRB_PARAMS_SVH
`define DCMRB_PARAMS_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define DCMRB_OFF_HW_REV      8'h00
`define DCMRB_OFF_DRV_REV     8'h01
`define DCMRB_OFF_STATUS      8'h04
`define DCMRB_OFF_SLOT_CTRL   8'h08
`define DCMRB_OFF_BAT_DEB     8'h0a
`define DCMRB_OFF_SHD_DEB     8'h0b
`define DCMRB_OFF_RESERVED    8'h0c
`define DCMRB_OFF_CLK_CTRL    8'h0d
`define DCMRB_OFF_DEV_CTRL    8'h0e
`define DCMRB_OFF_TEST_FIRST  8'h10
`define DCMRB_OFF_GP_PULLUP   8'h15

// ==========================================================================
// Status register fields
// ==========================================================================
`define DCMRB_ST_SHD_LEVEL    0
`define DCMRB_ST_SHD_INT      1
`define DCMRB_ST_BAT_GONE     2
`define DCMRB_ST_BAT_INT      3
`define DCMRB_ST_SLOT1_LO     4
`define DCMRB_ST_SLOT2_LO     6

// ==========================================================================
// Slot control fields
// ==========================================================================
`define DCMRB_SC_SLOT1_EN     0
`define DCMRB_SC_SLOT1_STATE  2
`define DCMRB_SC_SLOT2_EN     4
`define DCMRB_SC_SLOT2_STATE  6

// ==========================================================================
// Device control fields
// ==========================================================================
`define DCMRB_DC_BAT_INT_EN   2
`define DCMRB_DC_SHD_INT_EN   5

// ==========================================================================
// Reset values
// ==========================================================================
`define DCMRB_RST_ZERO        8'h00
`define DCMRB_RST_DEBOUNCE    8'h04
`define DCMRB_RST_DRV_REV     8'h00

`endif

// ==== hdl/dcmrb_pkg.sv ====
// Types shared by the dual card mux register bank.
package dcmrb_pkg;

  // ========================================================================
  // Slot status encoding
  // ========================================================================
  // Encoded state of one card slot as reported in the status register.
  typedef enum logic [1:0] {
    DCMRB_SLOT_DOWN     = 2'b00,
    DCMRB_SLOT_ISOLATED = 2'b01,
    DCMRB_SLOT_POWERED  = 2'b10,
    DCMRB_SLOT_ACTIVE   = 2'b11
  } dcmrb_slot_t;

  // ========================================================================
  // Register bank state
  // ========================================================================
  // Whole state of the bank, registered as one word.
  typedef struct packed {
    logic              shd_meta;   // First synchroniser stage of the shutdown pin.
    logic              shd_level;  // Second stage, the only copy logic reads.
    logic              shd_prev;   // Delayed shutdown detection level.
    logic              shd_int;    // Sticky shutdown interrupt flag.
    logic              bat_gone;   // Battery removed, debounce expired.
    logic              bat_int;    // Sticky battery removal interrupt flag.
    logic [7:0]        slot_ctrl;  // Slot interface control.
    logic [7:0]        bat_deb;    // Battery debounce count.
    logic [7:0]        shd_deb;    // Shutdown debounce count.
    logic [7:0]        clk_ctrl;   // Clock source control.
    logic [7:0]        dev_ctrl;   // Detection and direction control.
    logic [7:0]        gp_pullup;  // General purpose pull-up control.
    logic [4:0][7:0]   test;       // Factory test scratch registers.
    dcmrb_slot_t       slot1_st;   // Registered status of slot one.
    dcmrb_slot_t       slot2_st;   // Registered status of slot two.
    logic [7:0]        rdata;      // Read data held for the host.
    logic              rvalid;     // One-cycle read answer marker.
  } dcmrb_state_t;

endpackage

// ==== hdl/dcmrb_slot_status.sv ====
// Slot status encoder: control state bits and regulator enable to status code.
`timescale 1ns/1ps
`default_nettype none

module dcmrb_slot_status (
  input  wire logic [1:0]         i_state,   // State bits from slot control.
  input  wire logic               i_enable,  // Regulator enable bit.
  output var  dcmrb_pkg::dcmrb_slot_t o_status // Encoded slot status.
);

  // ========================================================================
  // Encoding
  // ========================================================================
  // The regulator enable dominates: an unpowered slot is always down, so a
  // host that forgets the order of writes never sees a false active slot.
  always_comb begin
    if (!i_enable) begin
      o_status = dcmrb_pkg::DCMRB_SLOT_DOWN;
    end else begin
      unique case (i_state)
        2'b00: o_status = dcmrb_pkg::DCMRB_SLOT_POWERED;
        2'b01: o_status = dcmrb_pkg::DCMRB_SLOT_ISOLATED;
        2'b10: o_status = dcmrb_pkg::DCMRB_SLOT_POWERED;
        2'b11: o_status = dcmrb_pkg::DCMRB_SLOT_ACTIVE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== dv/dcmrb_host_model.sv ====
// Host model that issues register reads and writes on the bank's strobe port.
`timescale 1ns/1ps
`default_nettype none

module dcmrb_host_model (
  input  wire logic       i_clock,    // Bank clock.
  input  wire logic [7:0] i_rdata,    // Read data from the bank.
  input  wire logic       i_rd_valid, // Read answer pulse.
  output logic            o_wr_en,    // Write strobe.
  output logic            o_rd_en,    // Read strobe.
  output logic      [7:0] o_addr,     // Register offset.
  output logic      [7:0] o_wdata     // Write data.
);
  // ==========================================================================
  // Idle state
  // ==========================================================================
  // Strobes start low so nothing is requested while the bank is in reset.
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // Released strobes go low and the address and data lines show the inverse of the last value, so a stale byte is never taken for a live one.
  task automatic release_bus();
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  // ==========================================================================
  // Access tasks
  // ==========================================================================
  // A write is taken at one rising edge; two idle cycles let the slot status encoder settle.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_clock);
    o_wr_en = 1'b1;
    o_addr  = addr;
    o_wdata = data;
    @(negedge i_clock);
    release_bus();
    repeat (2) @(negedge i_clock);
  endtask

  // A read is answered at the same edge that takes it; the answer is taken mid-cycle while its pulse stands.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(negedge i_clock);
    o_rd_en = 1'b1;
    o_addr  = addr;
    @(negedge i_clock);
    data  = i_rdata;
    valid = i_rd_valid;
    release_bus();
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking testbench of the dual card mux register bank.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  localparam logic [3:0] MFR = 4'h9; // Arbitrary manufacturer nibble.
  localparam logic [3:0] DEV = 4'h6; // Arbitrary device nibble.
  logic       clock, srst, wr_en, rd_en, pin, shd_det, bat_rem, rd_valid, gv;
  logic [7:0] addr, wdata, rdata, slot_ctrl, bat_deb, shd_deb, clk_ctrl, dev_ctrl, gp_pullup, status, got;
  int         error_cnt, check_count;
  // Offsets and reset values checked right after reset; 30h is unmapped.
  logic [7:0] rst_a [11] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h15, 8'h30};
  logic [7:0] rst_v [11] = '{{MFR, DEV}, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Writable offsets, factory test registers included.
  logic [7:0] rw_a [7] = '{8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h15, 8'h10, 8'h14};
  // Read-only, reserved and unmapped offsets whose writes must vanish.
  logic [7:0] ro_a [5] = '{8'h00, 8'h01, 8'h04, 8'h0c, 8'h30};

  dcmrb_register_bank #(.MFR_CODE(MFR), .DEV_CODE(DEV), .TEST_REGS(5)) DUT (
    .i_clock(clock), .i_srst(srst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .i_slot_two_shutdown_input(pin), .i_shutdown_detected(shd_det), .i_battery_removed(bat_rem),
    .o_rdata(rdata), .o_rd_valid(rd_valid), .o_slot_control(slot_ctrl), .o_battery_debounce(bat_deb),
    .o_shutdown_debounce(shd_deb), .o_clock_control(clk_ctrl), .o_device_control(dev_ctrl),
    .o_gp_pullup(gp_pullup), .o_status(status));

  dcmrb_host_model HOST (
    .i_clock(clock), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Expected slot status: a disabled regulator always reports powered down.
  function automatic logic [1:0] slot_code(input logic [1:0] st, input logic en);
    return !en ? 2'b00 : (st == 2'b00) ? 2'b10 : st;
  endfunction

  // Byte comparison with case equality, so an unknown never matches.
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Single flag comparison.
  task automatic check_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // A read must come with its answer pulse and the expected byte.
  task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
    HOST.read_reg(a, got, gv);
    check_bit(gv, 1'b1);
    check_byte(got, e);
  endtask

  // Single ending point of the run.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  // ==========================================================================
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // The tests need under two thousand cycles; fifty thousand means a hang.
  initial begin
    #500us;
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    error_cnt = 0;
    check_count = 0;
    srst = 1'b1;
    pin = 1'b0;
    shd_det = 1'b0;
    bat_rem = 1'b0;
    repeat (6) @(negedge clock);
    srst = 1'b0;
    // Reset values, identification byte and unmapped read.
    foreach (rst_a[i]) rd_check(rst_a[i], rst_v[i]); // reset value of every listed offset.
    $display("Test reset values done");
    // Writable registers read back and drive their ports.
    foreach (rw_a[i]) HOST.write_reg(rw_a[i], 8'h5a ^ rw_a[i]);
    foreach (rw_a[i]) rd_check(rw_a[i], 8'h5a ^ rw_a[i]);
    check_byte(bat_deb, 8'h50);
    check_byte(shd_deb, 8'h51);
    check_byte(clk_ctrl, 8'h57);
    check_byte(dev_ctrl, 8'h54);
    check_byte(gp_pullup, 8'h4f);
    HOST.write_reg(8'h0e, 8'h00);
    $display("Test read write done");
    // Every slot control value against the mapping of both status fields.
    for (int i = 0; i < 256; i++) begin
      HOST.write_reg(8'h08, i[7:0]);
      check_byte(slot_ctrl, i[7:0]); // state fields held.
      rd_check(8'h04, {slot_code(i[7:6], i[4]), slot_code(i[3:2], i[0]), 4'h0}); // mapping.
    end
    HOST.write_reg(8'h08, 8'h00);
    $display("Test slot status done");
    // Shutdown pin level reaches bit 0 through the synchroniser.
    pin = 1'b1;
    repeat (4) @(negedge clock);
    check_byte(status, 8'h01); // live status byte.
    rd_check(8'h04, 8'h01); // pin high.
    pin = 1'b0;
    repeat (4) @(negedge clock);
    rd_check(8'h04, 8'h00); // pin low.
    $display("Test shutdown pin done");
    // Events with both interrupts enabled; writes to read-only places in between.
    HOST.write_reg(8'h0e, 8'h24);
    bat_rem = 1'b1;
    repeat (2) @(negedge clock);
    foreach (ro_a[i]) HOST.write_reg(ro_a[i], 8'hff);
    rd_check(8'h04, 8'h0c); // flag survives writes.
    rd_check(8'h04, 8'h04); // flag cleared by read.
    shd_det = 1'b1;
    repeat (2) @(negedge clock);
    rd_check(8'h04, 8'h06); // shutdown flag raised.
    rd_check(8'h04, 8'h04); // shutdown flag cleared.
    rd_check(8'h00, {MFR, DEV}); // maker nibble kept.
    rd_check(8'h01, 8'h00); // driver revision kept.
    // Events with interrupts disabled set only the battery level.
    HOST.write_reg(8'h0e, 8'h00);
    bat_rem = 1'b0;
    shd_det = 1'b0;
    repeat (2) @(negedge clock);
    rd_check(8'h04, 8'h00); // battery back.
    bat_rem = 1'b1;
    shd_det = 1'b1;
    repeat (2) @(negedge clock);
    rd_check(8'h04, 8'h04); // no flag while disabled.
    $display("Test events done");
    complete_run();
  end
endmodule
`default_nettype wire
